// ### hdl/art_map.svh
// Register offsets, field positions, reset values and timing counts for the
// auto-reload timer with capture. Assumes an AXI4-Lite slave with 32-bit data.
`ifndef ART_MAP_SVH
`define ART_MAP_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define ART_OFF_CTRL      12'h000
`define ART_OFF_RELOAD_LO 12'h004
`define ART_OFF_RELOAD_HI 12'h008
`define ART_OFF_COUNT_LO  12'h00c
`define ART_OFF_COUNT_HI  12'h010
`define ART_OFF_CLKSEL    12'h014
`define ART_OFF_IRQ_EN    12'h018
`define ART_OFF_STATUS    12'h01c
`define ART_OFF_MASK      12'h020

// ****************************************************************
// Control register fields
// ****************************************************************
`define ART_CTRL_HIGH_FLAG 7
`define ART_CTRL_LOW_FLAG  6
`define ART_CTRL_LOW_IEN   5
`define ART_CTRL_CAPT_EN   4
`define ART_CTRL_SPLIT     3
`define ART_CTRL_RUN       2
`define ART_CTRL_SRC_HI    1
`define ART_CTRL_RESET     8'h00

// Clock select register: bit 0 low half, bit 1 high half
`define ART_CLKSEL_LOW  0
`define ART_CLKSEL_HIGH 1

// Status / mask: bit 0 high overflow, 1 low overflow, 2 capture
`define ART_EVT_HIGH 0
`define ART_EVT_LOW  1
`define ART_EVT_CAPT 2

// ****************************************************************
// Timing counts
// ****************************************************************
`define ART_SYS_DIV   4'd12
`define ART_EXT_DIV   3'd7
`define ART_BYTE_ZERO 8'h00
`define ART_BYTE_ONES 8'hff

`endif

// ### hdl/art_pkg.sv
// Types shared by the auto-reload timer with capture.
// Assumes the register map header is compiled alongside.
package art_pkg;

  typedef enum logic [1:0] {
    ART_SRC_DIV12 = 2'b00,
    ART_SRC_RTC   = 2'b01,
    ART_SRC_RSVD  = 2'b10,
    ART_SRC_EXT8  = 2'b11
  } art_src_type;

  typedef enum logic [2:0] {
    ART_RD_IDLE = 3'b001,
    ART_RD_DATA = 3'b010,
    ART_RD_WAIT = 3'b100
  } art_rd_type;

endpackage

// ### hdl/art_timer.sv
// Auto-reload timer with capture: 16-bit or split 8-bit counting, capture of
// the count on slow oscillator edges, AXI4-Lite register access.
// Assumes one 25 MHz system clock; rtc_osc and ext_osc are asynchronous pins.
//
// Functional notes
// - Count is two separately accessible bytes.
// - Split bit clear gives 16-bit auto-reload.
// - 16-bit wrap loads reload, sets high flag.
// - Timer irq enable requests irq on overflow.
// - Low irq enable adds low-byte wrap interrupts.
// - Split mode: two 8-bit auto-reload counters.
// - Split mode: run bit gates high only.
// - Per-half system_clock select, else source field.
// - Oscillator sources synchronised before counting.
// - Split mode wraps set their own flags.
// - Split irq on high, either with low.
// - Flags cleared only by software writes.
// - Capture enable bit selects capture mode.
// - Capture on rtc edge or eight ext cycles.
// - Capture copies count, sets high flag.
// - Control register layout, all bits reset zero.
//
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "art_map.svh"

module art_timer (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        rtc_osc,
  input  wire logic        ext_osc,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             timer_irq,
  output logic             irq
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0]  timer_control_r;
  logic [7:0]  reload_low_byte_r;
  logic [7:0]  reload_high_byte_r;
  logic [7:0]  count_low_byte_r;
  logic [7:0]  count_high_byte_r;
  logic [1:0]  clock_control_r;
  logic        timer_irq_enable_r;
  wire  [2:0]  status_r;
  logic [2:0]  mask_r;

  logic        aw_held_r;
  logic        w_held_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  art_pkg::art_rd_type rd_state_r;
  logic [11:0] araddr_r;

  logic        split_mode_bit;
  logic        run_control_bit;
  logic        capture_enable_bit;
  logic        low_byte_irq_enable;
  art_pkg::art_src_type alt_source_field;

  assign split_mode_bit      = timer_control_r[`ART_CTRL_SPLIT];
  assign run_control_bit     = timer_control_r[`ART_CTRL_RUN];
  assign capture_enable_bit  = timer_control_r[`ART_CTRL_CAPT_EN];
  assign low_byte_irq_enable = timer_control_r[`ART_CTRL_LOW_IEN];
  assign alt_source_field    = art_pkg::art_src_type'(timer_control_r[1:0]);

  // ****************************************************************
  // Source synchronisers and dividers
  // ****************************************************************
  logic [2:0] rtc_sync_r;
  logic [2:0] ext_sync_r;
  logic [3:0] div12_r;
  logic [2:0] ext_div_r;
  logic       rtc_tick;
  logic       ext_edge;
  logic       ext8_tick;
  logic       div12_tick;

  // Two flops per pin, a third stage only for edge detection
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rtc_sync_r <= 3'h0;
      ext_sync_r <= 3'h0;
    end else begin
      rtc_sync_r <= {rtc_sync_r[1:0], rtc_osc};
      ext_sync_r <= {ext_sync_r[1:0], ext_osc};
    end
  end

  assign rtc_tick = rtc_sync_r[1] & ~rtc_sync_r[2];
  assign ext_edge = ext_sync_r[1] & ~ext_sync_r[2];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div12_r   <= 4'h0;
      ext_div_r <= 3'h0;
    end else begin
      div12_r <= (div12_r == `ART_SYS_DIV - 4'd1) ? 4'h0 : div12_r + 4'd1;
      if (ext_edge) begin
        ext_div_r <= ext_div_r + 3'd1;
      end
    end
  end

  assign div12_tick = (div12_r == `ART_SYS_DIV - 4'd1);
  assign ext8_tick  = ext_edge & (ext_div_r == `ART_EXT_DIV);

  // Reserved source code never advances the counter
  logic alt_tick;
  always_comb begin
    unique case (alt_source_field)
      art_pkg::ART_SRC_DIV12: alt_tick = div12_tick;
      art_pkg::ART_SRC_RTC:   alt_tick = rtc_tick;
      art_pkg::ART_SRC_RSVD:  alt_tick = 1'b0;
      art_pkg::ART_SRC_EXT8:  alt_tick = ext8_tick;
    endcase
  end

  logic low_tick;
  logic high_tick;
  assign low_tick  = clock_control_r[`ART_CLKSEL_LOW]  ? 1'b1 : alt_tick;
  assign high_tick = clock_control_r[`ART_CLKSEL_HIGH] ? 1'b1 : alt_tick;

  // ****************************************************************
  // Counting, overflow and capture
  // ****************************************************************
  logic capt_event;
  logic low_en;
  logic high_en;
  logic low_wrap;
  logic high_wrap;

  assign capt_event = capture_enable_bit &
                      (timer_control_r[`ART_CTRL_SRC_HI] ? ext8_tick : rtc_tick);
  // In 16-bit mode the low half's select clocks the whole count
  assign low_en   = split_mode_bit ? low_tick : (run_control_bit & low_tick);
  assign high_en  = split_mode_bit ? (run_control_bit & high_tick)
                                   : (low_en & (count_low_byte_r == `ART_BYTE_ONES));
  assign low_wrap  = low_en & (count_low_byte_r == `ART_BYTE_ONES);
  assign high_wrap = high_en & (count_high_byte_r == `ART_BYTE_ONES);

  // Bus write decode
  logic        wr_fire;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_lane0;
  assign wr_addr  = aw_held_r ? awaddr_r : s_axi_awaddr;
  assign wr_data  = w_held_r ? wdata_r : s_axi_wdata;
  assign wr_strb  = w_held_r ? wstrb_r : s_axi_wstrb;
  assign wr_fire  = (aw_held_r | s_axi_awvalid) & (w_held_r | s_axi_wvalid) & ~s_axi_bvalid;
  assign wr_lane0 = wr_fire & wr_strb[0];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_low_byte_r <= `ART_BYTE_ZERO;
    end else if (wr_lane0 && wr_addr == `ART_OFF_COUNT_LO) begin
      count_low_byte_r <= wr_data[7:0];
    end else if (low_wrap && (split_mode_bit || high_wrap)) begin
      count_low_byte_r <= reload_low_byte_r;
    end else if (low_en) begin
      count_low_byte_r <= count_low_byte_r + 8'h01;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_high_byte_r <= `ART_BYTE_ZERO;
    end else if (wr_lane0 && wr_addr == `ART_OFF_COUNT_HI) begin
      count_high_byte_r <= wr_data[7:0];
    end else if (high_wrap) begin
      count_high_byte_r <= reload_high_byte_r;
    end else if (high_en) begin
      count_high_byte_r <= count_high_byte_r + 8'h01;
    end
  end

  // Capture takes priority over a software write in the same cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reload_low_byte_r  <= `ART_BYTE_ZERO;
      reload_high_byte_r <= `ART_BYTE_ZERO;
    end else if (capt_event) begin
      reload_low_byte_r  <= count_low_byte_r;
      reload_high_byte_r <= count_high_byte_r;
    end else begin
      if (wr_lane0 && wr_addr == `ART_OFF_RELOAD_LO) begin
        reload_low_byte_r <= wr_data[7:0];
      end
      if (wr_lane0 && wr_addr == `ART_OFF_RELOAD_HI) begin
        reload_high_byte_r <= wr_data[7:0];
      end
    end
  end

  // ****************************************************************
  // Control register and flags
  // ****************************************************************
  logic set_high;
  logic set_low;
  assign set_high = high_wrap | capt_event;
  assign set_low  = low_wrap;

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      timer_control_r <= `ART_CTRL_RESET;
    end else begin
      if (wr_lane0 && wr_addr == `ART_OFF_CTRL) begin
        timer_control_r <= wr_data[7:0];
      end
      if (set_high) begin
        timer_control_r[`ART_CTRL_HIGH_FLAG] <= 1'b1;
      end
      if (set_low) begin
        timer_control_r[`ART_CTRL_LOW_FLAG] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      clock_control_r    <= 2'h0;
      timer_irq_enable_r <= 1'b0;
      mask_r             <= 3'h0;
    end else if (wr_lane0) begin
      if (wr_addr == `ART_OFF_CLKSEL) begin
        clock_control_r <= wr_data[1:0];
      end
      if (wr_addr == `ART_OFF_IRQ_EN) begin
        timer_irq_enable_r <= wr_data[0];
      end
      if (wr_addr == `ART_OFF_MASK) begin
        mask_r <= wr_data[2:0];
      end
    end
  end

  // Level request that follows the flags until software clears them
  assign timer_irq = timer_irq_enable_r &
                     (timer_control_r[`ART_CTRL_HIGH_FLAG] |
                      (low_byte_irq_enable & timer_control_r[`ART_CTRL_LOW_FLAG]));

  // Sticky event status, write one to clear, set wins
  logic [2:0] evt_set;
  logic [2:0] evt_clr;
  assign evt_set = {capt_event, set_low, high_wrap};
  assign evt_clr = (wr_lane0 && wr_addr == `ART_OFF_STATUS) ? wr_data[2:0] : 3'h0;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_evt
      // One flop per status bit, so no vector has several drivers
      logic evt_r;
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          evt_r <= 1'b0;
        end else if (evt_set[gi]) begin
          evt_r <= 1'b1;
        end else if (evt_clr[gi]) begin
          evt_r <= 1'b0;
        end
      end
      assign status_r[gi] = evt_r;
    end
  endgenerate

  assign irq = |(status_r & mask_r);

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  logic wr_mapped;
  always_comb begin
    unique case (wr_addr)
      `ART_OFF_CTRL, `ART_OFF_RELOAD_LO, `ART_OFF_RELOAD_HI, `ART_OFF_COUNT_LO,
      `ART_OFF_COUNT_HI, `ART_OFF_CLKSEL, `ART_OFF_IRQ_EN, `ART_OFF_STATUS,
      `ART_OFF_MASK: wr_mapped = 1'b1;
      default:       wr_mapped = 1'b0;
    endcase
  end

  assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held_r & ~s_axi_bvalid;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      aw_held_r    <= 1'b0;
      w_held_r     <= 1'b0;
      awaddr_r     <= 12'h000;
      wdata_r      <= 32'h0000_0000;
      wstrb_r      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else if (wr_fire) begin
      aw_held_r    <= 1'b0;
      w_held_r     <= 1'b0;
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? 2'b00 : 2'b10;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  logic [31:0] rd_word;
  logic        rd_mapped;
  always_comb begin
    rd_word   = 32'h0000_0000;
    rd_mapped = 1'b1;
    unique case (araddr_r)
      `ART_OFF_CTRL:      rd_word[7:0] = timer_control_r;
      `ART_OFF_RELOAD_LO: rd_word[7:0] = reload_low_byte_r;
      `ART_OFF_RELOAD_HI: rd_word[7:0] = reload_high_byte_r;
      `ART_OFF_COUNT_LO:  rd_word[7:0] = count_low_byte_r;
      `ART_OFF_COUNT_HI:  rd_word[7:0] = count_high_byte_r;
      `ART_OFF_CLKSEL:    rd_word[1:0] = clock_control_r;
      `ART_OFF_IRQ_EN:    rd_word[0]   = timer_irq_enable_r;
      `ART_OFF_STATUS:    rd_word[2:0] = status_r;
      `ART_OFF_MASK:      rd_word[2:0] = mask_r;
      default:            rd_mapped    = 1'b0;
    endcase
  end

  assign s_axi_arready = (rd_state_r == art_pkg::ART_RD_IDLE);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_state_r   <= art_pkg::ART_RD_IDLE;
      araddr_r     <= 12'h000;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else begin
      unique case (rd_state_r)
        art_pkg::ART_RD_IDLE: begin
          if (s_axi_arvalid) begin
            araddr_r   <= s_axi_araddr;
            rd_state_r <= art_pkg::ART_RD_DATA;
          end
        end
        art_pkg::ART_RD_DATA: begin
          s_axi_rdata  <= rd_word;
          s_axi_rresp  <= rd_mapped ? 2'b00 : 2'b10;
          s_axi_rvalid <= 1'b1;
          rd_state_r   <= art_pkg::ART_RD_WAIT;
        end
        art_pkg::ART_RD_WAIT: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            rd_state_r   <= art_pkg::ART_RD_IDLE;
          end
        end
        default: rd_state_r <= art_pkg::ART_RD_IDLE;
      endcase
    end
  end

endmodule

// ### tb/art_timer_chk.sv
// Checker for the timer's bus handshakes and sticky interrupt outputs.
// Assumes binding to art_timer, one clock and an active-high reset.
`timescale 1ns/1ns
`include "art_map.svh"

module art_timer_chk (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        rtc_osc,
  input wire logic        ext_osc,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        timer_irq,
  input wire logic        irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // ****************************************************************
  // Sequences and properties
  // ****************************************************************
  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_ar_bad;
    s_ar_take ##0 (s_axi_araddr > `ART_OFF_MASK);
  endsequence
  sequence s_w_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_no_wr;
    !s_axi_awvalid && !s_axi_wvalid && !$past(s_axi_awvalid) && !$past(s_axi_wvalid);
  endsequence

  property p_read_lat;
    s_ar_take |-> ##[1:2] s_axi_rvalid;
  endproperty
  property p_read_bad;
    s_ar_bad |-> ##[1:2] (s_axi_rvalid && s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0);
  endproperty
  property p_write_resp;
    s_w_take |=> s_axi_bvalid;
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_byte;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  property p_irq_sticky;
    irq ##0 s_no_wr |=> irq;
  endproperty
  property p_tirq_sticky;
    timer_irq ##0 s_no_wr |=> timer_irq;
  endproperty

  a_read_lat: assert property (p_read_lat) else $error("read answer late");
  a_read_bad: assert property (p_read_bad) else $error("bad read answer");
  a_write_resp: assert property (p_write_resp) else $error("no write answer");
  a_r_hold: assert property (p_r_hold) else $error("read data moved");
  a_b_hold: assert property (p_b_hold) else $error("write answer moved");
  a_busy: assert property (p_busy) else $error("write taken while busy");
  a_byte: assert property (p_byte) else $error("upper read bits set");
  a_irq_sticky: assert property (p_irq_sticky) else $error("irq dropped");
  a_tirq_sticky: assert property (p_tirq_sticky) else $error("timer irq dropped");
endmodule

bind art_timer art_timer_chk u_art_timer_chk (.clk, .reset, .rtc_osc, .ext_osc,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .timer_irq, .irq);

// ### tb/art_timer_tb.sv
// Self-checking bench for the auto-reload timer with capture.
// Assumes the design, map header and checker are compiled alongside.
`timescale 1ns/1ns
`include "art_map.svh"

module art_timer_tb;
  logic        clk, reset, rtc_osc, ext_osc;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, timer_irq, irq;
  int          failures, check_count;

  art_timer u_art_timer (.clk, .reset, .rtc_osc, .ext_osc, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .timer_irq, .irq);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic guard(input int n, input int lim);
    if (n > lim) begin
      failures++;
      end_sim();
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    int   n;
    logic ah, wh, bh;
    n = 0;
    bh = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!bh) begin
      @(negedge clk);
      ah = s_axi_awvalid & s_axi_awready;
      wh = s_axi_wvalid & s_axi_wready;
      bh = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
      n++;
      guard(n, 50);
    end
    chk(r, (a > `ART_OFF_MASK) ? 2'b10 : 2'b00);
  endtask

  task automatic rd(input logic [11:0] a);
    int   n;
    logic ah, rh;
    n = 0;
    rh = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!rh) begin
      @(negedge clk);
      ah = s_axi_arvalid & s_axi_arready;
      rh = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      if (ah) s_axi_arvalid <= 1'b0;
      n++;
      guard(n, 50);
    end
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    chk(d, e);
  endtask

  task automatic wait_irq(input bit t);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      guard(n, 300);
    end while ((t ? timer_irq : irq) !== 1'b1);
    @(posedge clk);
  endtask

  task automatic pulse(input bit x);
    if (x) ext_osc <= 1'b1;
    else rtc_osc <= 1'b1;
    tick(4);
    if (x) ext_osc <= 1'b0;
    else rtc_osc <= 1'b0;
    tick(4);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    for (int i = 0; i <= 8; i++) rdc(12'(4 * i), 32'h0);
    rdc(12'h024, 32'h0);
    chk(r, 2'b10);
    wr(12'h024, 32'hff);
  endtask

  task automatic t_rw;
    for (int i = 1; i <= 4; i++) begin
      wr(12'(4 * i), 32'ha0 + i);
      rdc(12'(4 * i), 32'ha0 + i);
    end
    s_axi_wstrb <= 4'h0;
    wr(`ART_OFF_RELOAD_LO, 32'h5a);
    s_axi_wstrb <= 4'h1;
    rdc(`ART_OFF_RELOAD_LO, 32'ha1);
  endtask

  task automatic t_16bit;
    wr(`ART_OFF_CLKSEL, 32'h1);
    wr(`ART_OFF_RELOAD_LO, 32'h34);
    wr(`ART_OFF_RELOAD_HI, 32'h12);
    wr(`ART_OFF_COUNT_HI, 32'hff);
    wr(`ART_OFF_COUNT_LO, 32'hf0);
    wr(`ART_OFF_IRQ_EN, 32'h1);
    wr(`ART_OFF_MASK, 32'h0);
    wr(`ART_OFF_CTRL, 32'h04);
    wait_irq(1'b1);
    rdc(`ART_OFF_CTRL, 32'hc4);
    wr(`ART_OFF_CTRL, 32'h00);
    rdc(`ART_OFF_COUNT_HI, 32'h12);
    chk(timer_irq, 1'b0);
    rdc(`ART_OFF_STATUS, 32'h3);
    chk(irq, 1'b0);
    wr(`ART_OFF_MASK, 32'h1);
    chk(irq, 1'b1);
    wr(`ART_OFF_STATUS, 32'h3);
    chk(irq, 1'b0);
  endtask

  task automatic t_low;
    wr(`ART_OFF_COUNT_HI, 32'h00);
    wr(`ART_OFF_COUNT_LO, 32'hf8);
    wr(`ART_OFF_CTRL, 32'h24);
    wait_irq(1'b1);
    rdc(`ART_OFF_CTRL, 32'h64);
    rdc(`ART_OFF_COUNT_HI, 32'h01);
    wr(`ART_OFF_CTRL, 32'h00);
  endtask

  task automatic t_split;
    wr(`ART_OFF_RELOAD_LO, 32'hf0);
    wr(`ART_OFF_RELOAD_HI, 32'ha0);
    wr(`ART_OFF_COUNT_LO, 32'hfe);
    wr(`ART_OFF_COUNT_HI, 32'h55);
    wr(`ART_OFF_CTRL, 32'h08);
    tick(20);
    rdc(`ART_OFF_COUNT_HI, 32'h55);
    rdc(`ART_OFF_CTRL, 32'h48);
    chk(timer_irq, 1'b0);
    rd(`ART_OFF_COUNT_LO);
    chk(d[7:4], 4'hf);
    wr(`ART_OFF_COUNT_HI, 32'hff);
    wr(`ART_OFF_CTRL, 32'h0c);
    wait_irq(1'b1);
    rd(`ART_OFF_CTRL);
    chk(d[7], 1'b1);
    rd(`ART_OFF_COUNT_HI);
    chk(d[7:4], 4'ha);
    wr(`ART_OFF_CTRL, 32'h2c);
    wait_irq(1'b1);
    rd(`ART_OFF_CTRL);
    chk(d[7:6], 2'b01);
    wr(`ART_OFF_CLKSEL, 32'h2);
    wr(`ART_OFF_COUNT_HI, 32'h00);
    tick(24);
    rd(`ART_OFF_COUNT_HI);
    chk(d >= 32'h18 && d <= 32'h1c, 1'b1);
    wr(`ART_OFF_CTRL, 32'h00);
  endtask

  task automatic t_src;
    logic [31:0] f;
    wr(`ART_OFF_CLKSEL, 32'h0);
    wr(`ART_OFF_COUNT_LO, 32'h00);
    wr(`ART_OFF_CTRL, 32'h04);
    tick(120);
    wr(`ART_OFF_CTRL, 32'h00);
    rd(`ART_OFF_COUNT_LO);
    f = d;
    chk(f >= 9 && f <= 12, 1'b1);
    wr(`ART_OFF_CTRL, 32'h06);
    tick(60);
    wr(`ART_OFF_CTRL, 32'h05);
    repeat (3) pulse(1'b0);
    wr(`ART_OFF_CTRL, 32'h07);
    repeat (8) pulse(1'b1);
    wr(`ART_OFF_CTRL, 32'h00);
    rdc(`ART_OFF_COUNT_LO, f + 4);
  endtask

  task automatic t_capture;
    logic [15:0] cap;
    logic [15:0] cap2;
    int          n;
    time         t0;
    time         t1;
    wr(`ART_OFF_CLKSEL, 32'h1);
    wr(`ART_OFF_COUNT_HI, 32'h00);
    wr(`ART_OFF_COUNT_LO, 32'h00);
    wr(`ART_OFF_STATUS, 32'h7);
    wr(`ART_OFF_MASK, 32'h4);
    wr(`ART_OFF_CTRL, 32'h14);
    tick(30);
    t0 = $time;
    pulse(1'b0);
    chk(irq, 1'b1);
    rd(`ART_OFF_CTRL);
    chk(d[7], 1'b1);
    rd(`ART_OFF_RELOAD_LO);
    cap[7:0] = d[7:0];
    rd(`ART_OFF_RELOAD_HI);
    cap[15:8] = d[7:0];
    chk(cap >= 16'h0018 && cap <= 16'h0030, 1'b1);
    t1 = $time;
    pulse(1'b0);
    rd(`ART_OFF_RELOAD_LO);
    cap2[7:0] = d[7:0];
    rd(`ART_OFF_RELOAD_HI);
    cap2[15:8] = d[7:0];
    chk(cap2 - cap, 16'((t1 - t0) / 64'd40));
    wr(`ART_OFF_CTRL, 32'h12);
    rd(`ART_OFF_COUNT_HI);
    chk(d[7:0] > cap[15:8] || d[7:0] == cap[15:8], 1'b1);
    chk(cap < 16'h0100, 1'b1);
    wr(`ART_OFF_STATUS, 32'h7);
    n = 0;
    do begin
      pulse(1'b1);
      n++;
      rd(`ART_OFF_STATUS);
    end while (!d[2] && n < 9);
    chk(n, 8);
    wr(`ART_OFF_STATUS, 32'h4);
    repeat (7) pulse(1'b1);
    rd(`ART_OFF_STATUS);
    chk(d[2], 1'b0);
    pulse(1'b1);
    rd(`ART_OFF_STATUS);
    chk(d[2], 1'b1);
  endtask

  initial begin
    failures = 0;
    check_count = 0;
    reset = 1'b1;
    {rtc_osc, ext_osc, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'h1;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset();
    t_rw();
    t_16bit();
    t_low();
    t_split();
    t_src();
    t_capture();
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    end_sim();
  end
endmodule
